// file: rtl/cdc_regs.v
// Purpose: Control, identity and error-capture registers of the code
//          decompression controller, reached through an address/data pair.
// Assumes: Errors arrive as one-cycle pulses with master number and cause.
// Notes:   Vector bit 31 is big-endian bit 0 throughout.
//
// Overview of operation
// - Table origins keep bits 21:31 only
// - Region base in bits 0:9
// - Size codes 0101..1111, 4MB to 4GB
// - Bit 31 enables region decoding
// - Enabled region claims its address space
// - Config bit 31 disables decompression
// - Bit 29 clears buffer, reads zero
// - Bit 28 sleep enable, 18:27 delay
// - Fixed read-only identity word
// - Fixed read-only revision word
// - Capture processor-side error address
// - Capture memory-side error address
// - Error type codes 000..011
// - Three six-bit master status groups
// - Direction reads 1 for read errors
// - Lock input sets field lock
// - Lock input sets address lock, holds addresses
// - Page attribute marks compressed fetches
`timescale 1ns/100ps
`include "cdc_regs_map.vh"

module cdc_regs #(
  parameter [31:0] IDENT_VALUE = 32'h0000_0a5a, // Arbitrary value
  parameter [31:0] REVISION_VALUE = 32'h0000_0001 // Arbitrary value
) (
  input wire clk,
  input wire rst,
  input wire clk_en,
  // Register port
  input wire [9:0] port_addr,
  input wire port_wr,
  input wire port_rd,
  input wire [31:0] port_wdata,
  output reg [31:0] port_rdata,
  output reg port_ack,
  // Error reports from the datapath
  input wire err_valid,
  input wire [1:0] err_master,
  input wire [2:0] err_type,
  input wire err_is_read,
  input wire lock_error_input,
  input wire [31:0] err_cpu_addr,
  input wire [31:0] err_mem_addr,
  // Fetch classification
  input wire [31:0] fetch_addr,
  input wire compressed_page_attribute,
  // Controls towards the datapath
  output reg region_hit,
  output reg fetch_compressed,
  output reg buffer_clear_pulse,
  output reg decompress_disable_bit,
  output reg sleep_enable_bit,
  output reg [9:0] sleep_delay_value,
  output reg [10:0] table_origin_sel
);

  reg [10:0] offset_reg;
  reg [31:0] origin_reg [0:3];
  reg [31:0] region0_reg;
  reg [31:0] region1_reg;
  reg [31:0] config_reg;
  reg [31:0] cpu_ear_reg;
  reg [31:0] mem_ear_reg;
  reg [31:0] status_reg;
  reg [31:0] rdata_next;
  wire hit0;
  wire hit1;
  wire data_wr;
  wire data_rd;
  wire [4:0] grp_lsb;
  wire any_addr_lock;
  wire grp_field_lock;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Status group base bit of a master
  function [4:0] grp_base;
    input [1:0] m;
    begin
      grp_base = 5'd26 - {m, 2'b00} - {1'b0, m, 1'b0};
    end
  endfunction

  assign data_wr = clk_en && port_wr && (port_addr == `CDC_PORT_DATA);
  assign data_rd = clk_en && port_rd && (port_addr == `CDC_PORT_DATA);
  assign grp_lsb = grp_base(err_master);
  assign any_addr_lock = status_reg[26] | status_reg[20] | status_reg[14];
  assign grp_field_lock = status_reg[grp_lsb + 5'd1];

  cdc_region_match u_match0 (
    .region_word(region0_reg),
    .addr(fetch_addr),
    .hit(hit0)
  );

  cdc_region_match u_match1 (
    .region_word(region1_reg),
    .addr(fetch_addr),
    .hit(hit1)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  always @* begin
    rdata_next = `CDC_RST_WORD;
    if (port_addr == `CDC_PORT_ADDR) begin
      rdata_next = {21'h0, offset_reg};
    end else begin
      case (offset_reg)
        `CDC_OFF_ORIGIN0: rdata_next = origin_reg[0];
        `CDC_OFF_ORIGIN1: rdata_next = origin_reg[1];
        `CDC_OFF_ORIGIN2: rdata_next = origin_reg[2];
        `CDC_OFF_ORIGIN3: rdata_next = origin_reg[3];
        `CDC_OFF_REGION0: rdata_next = region0_reg;
        `CDC_OFF_REGION1: rdata_next = region1_reg;
        `CDC_OFF_CONFIG: rdata_next = config_reg;
        `CDC_OFF_IDENT: rdata_next = IDENT_VALUE;
        `CDC_OFF_REVISION: rdata_next = REVISION_VALUE;
        `CDC_OFF_CPU_EAR: rdata_next = cpu_ear_reg;
        `CDC_OFF_MEM_EAR: rdata_next = mem_ear_reg;
        `CDC_OFF_STATUS: rdata_next = status_reg;
        default: rdata_next = `CDC_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_reg <= 11'h000;
      for (i = 0; i < 4; i = i + 1) begin
        origin_reg[i] <= `CDC_RST_WORD;
      end
      region0_reg <= `CDC_RST_WORD;
      region1_reg <= `CDC_RST_WORD;
      config_reg <= `CDC_RST_WORD;
      cpu_ear_reg <= `CDC_RST_WORD;
      mem_ear_reg <= `CDC_RST_WORD;
      status_reg <= `CDC_RST_WORD;
      port_rdata <= `CDC_RST_WORD;
      port_ack <= 1'b0;
      buffer_clear_pulse <= 1'b0;
    end else if (clk_en) begin
      port_ack <= port_wr | port_rd;
      buffer_clear_pulse <= 1'b0;
      if (port_rd) begin
        port_rdata <= rdata_next;
      end
      // Address first, then data
      if (port_wr && port_addr == `CDC_PORT_ADDR) begin
        offset_reg <= port_wdata[10:0];
      end
      if (data_wr) begin
        case (offset_reg)
          `CDC_OFF_ORIGIN0, `CDC_OFF_ORIGIN1,
          `CDC_OFF_ORIGIN2, `CDC_OFF_ORIGIN3: begin
            origin_reg[offset_reg[1:0]] <=
              port_wdata & `CDC_ORIGIN_MASK;
          end
          `CDC_OFF_REGION0: region0_reg <=
            port_wdata & `CDC_REGION_MASK;
          `CDC_OFF_REGION1: region1_reg <=
            port_wdata & `CDC_REGION_MASK;
          `CDC_OFF_CONFIG: begin
            // Clear bit is never stored, so it reads back zero
            config_reg <= port_wdata & `CDC_CONFIG_MASK &
              ~(32'h1 << `CDC_CFG_CLEAR);
            buffer_clear_pulse <= port_wdata[`CDC_CFG_CLEAR];
          end
          default: begin
          end
        endcase
      end
      // Error capture; set wins over a same-cycle clear
      if (data_wr && offset_reg == `CDC_OFF_STATUS) begin
        status_reg <= status_reg & ~port_wdata & `CDC_STATUS_MASK;
      end
      if (err_valid && err_master != 2'd3) begin
        if (!grp_field_lock) begin
          status_reg[grp_lsb + 5'd5] <= err_type[2];
          status_reg[grp_lsb + 5'd4] <= err_type[1];
          status_reg[grp_lsb + 5'd3] <= err_type[0];
          status_reg[grp_lsb + 5'd2] <= err_is_read;
          status_reg[grp_lsb + 5'd1] <= lock_error_input;
          status_reg[grp_lsb] <= lock_error_input;
        end
        if (!any_addr_lock) begin
          cpu_ear_reg <= err_cpu_addr;
          mem_ear_reg <= err_mem_addr;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the datapath

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      region_hit <= 1'b0;
      fetch_compressed <= 1'b0;
      decompress_disable_bit <= 1'b0;
      sleep_enable_bit <= 1'b0;
      sleep_delay_value <= 10'h000;
      table_origin_sel <= 11'h000;
    end else if (clk_en) begin
      region_hit <= hit0 | hit1;
      // Attribute honoured only while decompression is enabled
      fetch_compressed <= (hit0 | hit1) && compressed_page_attribute &&
        !config_reg[`CDC_CFG_DISABLE];
      decompress_disable_bit <= config_reg[`CDC_CFG_DISABLE];
      sleep_enable_bit <= config_reg[`CDC_CFG_SLEEP];
      sleep_delay_value <= config_reg[`CDC_SLEEP_DELAY_VALUE_MSB:`CDC_SLEEP_DELAY_VALUE_LSB];
      // Origin of region 1 when it hits, else region 0
      table_origin_sel <= hit1 ? origin_reg[1][10:0] :
        origin_reg[0][10:0];
    end
  end

endmodule // cdc_regs

// file: rtl/cdc_regs_map.vh
// Purpose: Offsets, fields and reset values of the decompression control
//          register bank.
// Assumes: Big-endian bit numbering, bit 0 is the MSB (vector bit 31).
// Notes:   Definitions only.
`ifndef CDC_REGS_MAP_VH
`define CDC_REGS_MAP_VH

// Port addresses of the indirect pair
`define CDC_PORT_ADDR 10'h014
`define CDC_PORT_DATA 10'h015

// Indirect offsets
`define CDC_OFF_ORIGIN0 11'h000
`define CDC_OFF_ORIGIN1 11'h001
`define CDC_OFF_ORIGIN2 11'h002
`define CDC_OFF_ORIGIN3 11'h003
`define CDC_OFF_REGION0 11'h004
`define CDC_OFF_REGION1 11'h005
`define CDC_OFF_CONFIG 11'h040
`define CDC_OFF_IDENT 11'h041
`define CDC_OFF_REVISION 11'h042
`define CDC_OFF_CPU_EAR 11'h050
`define CDC_OFF_MEM_EAR 11'h051
`define CDC_OFF_STATUS 11'h052

// Writable masks (vector numbering, bit 31 = big-endian bit 0)
`define CDC_ORIGIN_MASK 32'h0000_07ff
`define CDC_REGION_MASK 32'hffcf_0001
`define CDC_CONFIG_MASK 32'h0000_3ffd

// Configuration fields (vector numbering)
`define CDC_CFG_DISABLE 0
`define CDC_CFG_CLEAR 2
`define CDC_CFG_SLEEP 3
`define CDC_SLEEP_DELAY_VALUE_LSB 4
`define CDC_SLEEP_DELAY_VALUE_MSB 13

// Region fields (vector numbering)
`define CDC_REG_EN 0
`define CDC_RSIZE_LSB 16
`define CDC_RSIZE_MSB 19
`define CDC_RBASE_LSB 22
`define CDC_RSIZE_MIN 4'h5

// Error status: group of master m starts at vector bit 31-6m
`define CDC_STATUS_MASK 32'hffff_c000

// Reset values
`define CDC_RST_WORD 32'h0000_0000

`endif

// file: rtl/cdc_region_match.v
// Purpose: Address match for one decode region.
// Assumes: Size code 5 is 4MB, each step doubles, 15 is 4GB.
// Notes:   Reserved size codes never match.
`timescale 1ns/100ps
`include "cdc_regs_map.vh"

module cdc_region_match (
  input wire [31:0] region_word,
  input wire [31:0] addr,
  output wire hit
);

  wire [3:0] size_code;
  wire [31:0] size_mask;
  wire size_ok;

  assign size_code = region_word[`CDC_RSIZE_MSB:`CDC_RSIZE_LSB];
  // Mask covers the bits inside the region, 22 + (code - 5) bits
  // Six-bit amount so code 15 shifts by 32 and spans the whole space
  assign size_mask = ~(32'hffff_ffff << (6'd17 + {2'b00, size_code}));
  assign size_ok = (size_code >= `CDC_RSIZE_MIN);
  // Base holds the top ten bits; larger regions ignore the low base bits
  assign hit = region_word[`CDC_REG_EN] && size_ok &&
    (((addr ^ region_word) & ~size_mask & 32'hffc0_0000) == 32'h0);

endmodule // cdc_region_match

// file: sim/cdc_regs_properties.sv
// Purpose: Port-level properties of cdc_regs
// Assumes: Ack and levels one cycle after cause
// Notes: Bound after the module
`timescale 1ns/100ps
module cdc_regs_chk (
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire [9:0] port_addr,
  input wire port_wr,
  input wire port_rd,
  input wire [31:0] port_wdata,
  input wire [31:0] port_rdata,
  input wire port_ack,
  input wire compressed_page_attribute,
  input wire region_hit,
  input wire fetch_compressed,
  input wire buffer_clear_pulse,
  input wire decompress_disable_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req;
    clk_en && (port_wr || port_rd);
  endsequence
  sequence s_off;
    decompress_disable_bit[*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_ack_timing: assert property (s_req |=> port_ack)
    else $error("ack missing after request");
  chk_ack_cause: assert property (port_ack && $past(clk_en) |->
    $past(port_wr || port_rd))
    else $error("ack without request");
  chk_freeze_ack: assert property (!clk_en |=> $stable(port_ack))
    else $error("ack moved while frozen");
  chk_rdata_hold: assert property (!$past(port_rd && clk_en) |->
    $stable(port_rdata))
    else $error("read data moved without read");
  chk_clear_cause: assert property (
    buffer_clear_pulse && $past(clk_en) |->
    $past(port_wr && port_addr == 10'h015 && port_wdata[2]))
    else $error("clear pulse without write");
  chk_disable_gate: assert property (s_off |-> !fetch_compressed)
    else $error("compressed fetch while disabled");
  chk_hit_needed: assert property (fetch_compressed |-> region_hit)
    else $error("compressed fetch outside region");
  chk_attr_needed: assert property (
    fetch_compressed && $past(clk_en) |-> $past(compressed_page_attribute))
    else $error("compressed fetch without attribute");
endmodule // cdc_regs_chk

bind cdc_regs cdc_regs_chk i_cdc_regs_chk (.clk(clk), .rst(rst),
  .clk_en(clk_en), .port_addr(port_addr), .port_wr(port_wr),
  .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
  .port_ack(port_ack), .region_hit(region_hit),
  .compressed_page_attribute(compressed_page_attribute),
  .fetch_compressed(fetch_compressed),
  .buffer_clear_pulse(buffer_clear_pulse),
  .decompress_disable_bit(decompress_disable_bit));

// file: sim/cdc_err_model.sv
// Purpose: Datapath side that reports errors
// Assumes: One-cycle report pulse
// Notes: Released address lines show inverted values
`timescale 1ns/100ps
module cdc_err_model (
  input wire clk,
  output reg err_valid,
  output reg [1:0] err_master,
  output reg [2:0] err_type,
  output reg err_is_read,
  output reg lock_error_input,
  output reg [31:0] err_cpu_addr,
  output reg [31:0] err_mem_addr
);
  initial {err_valid, err_master, err_type, err_is_read} = 7'h00;
  initial {lock_error_input, err_cpu_addr, err_mem_addr} = 65'h0;
  task report(input [1:0] m, input [2:0] t, input lk, input [31:0] ca,
              input [31:0] ma);
    begin
      @(posedge clk);
      #1;
      {err_valid, err_master, err_type} = {1'b1, m, t};
      {err_is_read, lock_error_input} = {1'b1, lk};
      {err_cpu_addr, err_mem_addr} = {ca, ma};
      @(posedge clk);
      #1;
      err_valid = 1'b0;
      // Stale values would hide a late capture
      {err_cpu_addr, err_mem_addr} = ~{ca, ma};
    end
  endtask
endmodule // cdc_err_model

// file: sim/tb_cdc_regs.sv
// Purpose: Self-checking bench for cdc_regs
// Assumes: Offset then data access, ack one cycle later
// Notes: Expected reads queued, checked at ack
`timescale 1ns/100ps
`include "cdc_regs_map.vh"
module tb_cdc_regs;
  localparam [31:0] ID_V = 32'h0000_1234; // Arbitrary value
  localparam [31:0] REV_V = 32'h0000_0007; // Arbitrary value
  reg clk = 1'b0, rst = 1'b1, clk_en = 1'b1, port_wr = 1'b0;
  reg port_rd = 1'b0, attr = 1'b0;
  reg [9:0] port_addr = 10'h000;
  reg [31:0] port_wdata = 32'h0, fetch_addr = 32'h0, b, r, st;
  wire [31:0] port_rdata, ca, ma;
  wire [9:0] sdv;
  wire [10:0] tos;
  wire [2:0] et;
  wire [1:0] em;
  wire port_ack, ev, rd_e, lk, hit, fc, clr, dis, slp;
  integer failures = 0, samples_checked = 0, i;
  reg [63:0] exp_q[$];
  reg [63:0] e;
  cdc_regs #(.IDENT_VALUE(ID_V), .REVISION_VALUE(REV_V)) i_cdc_regs (
    .clk(clk), .rst(rst), .clk_en(clk_en), .port_addr(port_addr),
    .port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata),
    .port_rdata(port_rdata), .port_ack(port_ack), .err_valid(ev),
    .err_master(em), .err_type(et), .err_is_read(rd_e),
    .lock_error_input(lk), .err_cpu_addr(ca), .err_mem_addr(ma),
    .fetch_addr(fetch_addr), .compressed_page_attribute(attr),
    .region_hit(hit), .fetch_compressed(fc), .buffer_clear_pulse(clr),
    .decompress_disable_bit(dis), .sleep_enable_bit(slp),
    .sleep_delay_value(sdv), .table_origin_sel(tos));
  cdc_err_model i_cdc_err_model (.clk(clk), .err_valid(ev),
    .err_master(em), .err_type(et), .err_is_read(rd_e),
    .lock_error_input(lk), .err_cpu_addr(ca), .err_mem_addr(ma));
  ////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  task check_word(input string nm, input [31:0] x, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        failures = failures + 1;
        $display("FAIL %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task bus(input w, input [9:0] a, input [31:0] d, input [63:0] x);
    begin
      {port_wr, port_rd, port_addr, port_wdata} = {w, !w, a, d};
      exp_q.push_back(x);
      @(posedge clk);
      #1;
    end
  endtask
  task idle;
    begin
      {port_wr, port_rd} = 2'b00;
      @(posedge clk);
      #1;
    end
  endtask
  task reg_wr(input [10:0] o, input [31:0] d);
    begin
      bus(1'b1, 10'h014, {21'h0, o}, 64'h0);
      bus(1'b1, 10'h015, d, 64'h0);
      idle;
    end
  endtask
  task reg_rd(input [10:0] o, input [31:0] x);
    begin
      bus(1'b1, 10'h014, {21'h0, o}, 64'h0);
      bus(1'b0, 10'h015, 32'h0, {32'hffff_ffff, x});
      idle;
    end
  endtask
  task probe(input [31:0] w, input [31:0] a, input at, input [1:0] x);
    begin
      reg_wr(`CDC_OFF_REGION0, w);
      {fetch_addr, attr} = {a, at};
      repeat (2) @(posedge clk);
      #1;
      check_word("hit_fetch", {30'h0, x}, {30'h0, hit, fc});
    end
  endtask
  task final_report;
    begin
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(negedge clk)
    if (port_ack === 1'b1) begin
      e = exp_q.pop_front();
      check_word("port_rdata", e[31:0], port_rdata & e[63:32]);
    end
  initial begin
    repeat (3000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
  initial begin
    void'($urandom(96));
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    reg_rd(`CDC_OFF_CONFIG, 32'h0);
    reg_rd(`CDC_OFF_IDENT, ID_V);
    reg_wr(`CDC_OFF_REVISION, 32'hffff_ffff);
    reg_rd(`CDC_OFF_REVISION, REV_V);
    reg_rd(11'h013, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      r = $urandom;
      reg_wr(i[10:0], r);
      reg_rd(i[10:0], r & (i < 4 ? 32'h7ff : 32'hffcf_0001));
    end
    reg_wr(`CDC_OFF_CONFIG, 32'hffff_ffff);
    reg_rd(`CDC_OFF_CONFIG, 32'h3ff9);
    check_word("cfg_levels", 32'hfff, {20'h0, dis, slp, sdv});
    bus(1'b1, 10'h014, {21'h0, `CDC_OFF_CONFIG}, 64'h0);
    bus(1'b1, 10'h015, 32'h4, 64'h0);
    check_word("clear_pulse", 32'h1, {31'h0, clr});
    idle;
    check_word("clear_pulse", 32'h0, {31'h0, clr});
    // Region 1 off so only region 0 can claim
    reg_wr(`CDC_OFF_REGION1, 32'h0);
    reg_wr(`CDC_OFF_CONFIG, 32'h0);
    {b, r} = {$urandom, $urandom};
    probe({b[9:0], 22'h05_0001}, {b[9:0], r[21:0]}, 1, 2'b11);
    probe({b[9:0], 22'h05_0001}, {b[9:0] + 10'h1, r[21:0]}, 1, 0);
    probe({b[9:0], 22'h05_0001}, {b[9:0], r[21:0]}, 0, 2'b10);
    probe({b[9:0], 22'h04_0001}, {b[9:0], r[21:0]}, 1, 0);
    probe({b[9:0], 22'h05_0000}, {b[9:0], r[21:0]}, 1, 0);
    probe({~b[9:0], 22'h0f_0001}, {b[9:0], r[21:0]}, 1, 2'b11);
    reg_wr(`CDC_OFF_CONFIG, 32'h1);
    probe({b[9:0], 22'h05_0001}, {b[9:0], r[21:0]}, 1, 2'b10);
    reg_wr(`CDC_OFF_ORIGIN0, b);
    check_word("origin_sel", {21'h0, b[10:0]}, {21'h0, tos});
    reg_wr(`CDC_OFF_ORIGIN1, r);
    reg_wr(`CDC_OFF_REGION1, {b[9:0], 22'h05_0001});
    check_word("origin_sel", {21'h0, r[10:0]}, {21'h0, tos});
    // Offset write while frozen must be dropped
    {clk_en, port_wr, port_addr, port_wdata} = {2'b01, 10'h014, 32'h42};
    repeat (3) @(posedge clk);
    #1 {clk_en, port_wr} = 2'b10;
    st = {21'h0, `CDC_OFF_REGION1};
    bus(1'b0, 10'h014, 32'h0, {32'hffff_ffff, st});
    idle;
    i_cdc_err_model.report(2'd0, 3'd3, 1'b0, r, b);
    reg_rd(`CDC_OFF_CPU_EAR, r);
    reg_rd(`CDC_OFF_MEM_EAR, b);
    st = 32'h7000_0000;
    reg_rd(`CDC_OFF_STATUS, st);
    i_cdc_err_model.report(2'd2, 3'd2, 1'b1, b, r);
    st = st | (32'h17 << 14);
    reg_rd(`CDC_OFF_STATUS, st);
    i_cdc_err_model.report(2'd1, 3'd1, 1'b0, ~r, ~b);
    i_cdc_err_model.report(2'd2, 3'd0, 1'b0, r, b);
    reg_rd(`CDC_OFF_STATUS, st | (32'h0c << 20));
    reg_rd(`CDC_OFF_CPU_EAR, b);
    reg_rd(`CDC_OFF_MEM_EAR, r);
    reg_wr(`CDC_OFF_STATUS, 32'hffff_ffff);
    reg_rd(`CDC_OFF_STATUS, 32'h0);
    i_cdc_err_model.report(2'd0, 3'd1, 1'b0, ~b, r);
    reg_rd(`CDC_OFF_CPU_EAR, ~b);
    // Master number 3 is not a reporting master
    i_cdc_err_model.report(2'd3, 3'd0, 1'b1, r, r);
    reg_rd(`CDC_OFF_CPU_EAR, ~b);
    reg_rd(`CDC_OFF_STATUS, 32'h3000_0000);
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule // tb_cdc_regs
